// ===== core/dmars_core.sv
/*
  External request front end of DMA channel 2: samples the request
  pin, paces bus cycles, inserts dummy cycles, drives the accept
  strobe and acknowledge, and keeps the reload counter.
  Assumes a synchronous request pin, wait counts from the bus state
  controller, and a classic Wishbone master for the registers.
*/
// The placing of the registers and the Wishbone slave port are this design's own decisions.
// Operation
// - bus cycle length from wait control settings
// - request detected by falling edge or low level
// - bus cycle starts three states after detection
// - burst single address begins with dummy cycle
// - dummy cycle: no acknowledge, no count change
// - resample from cycle before each transfer
// - undetected request is sampled every cycle
// - accept strobe once per first request sampling
// - cycle steal timing same for all options
// - acknowledge spans each single address transfer
// - level burst runs back to back while requested; here only if the next request was sampled three states before the unit ends
// - dummy cycle ignored when timing second sampling
// - new dummy only after burst was interrupted
// - edge burst samples once, runs whole count
// - dual edge burst resumes after accept strobe
// - single edge burst resumes with one dummy
// - reload source address every four units
// - reload works for byte, halfword, word
// - count drops by one per unit moved
// - halt events clear reload counter only
`timescale 1ns/100ps
module dmars_core #(
  parameter int AW = 32
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone register slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Bus state controller wait settings and system events
  input  wire logic [3:0]  wait_control_one_i,
  input  wire logic [3:0]  wait_control_two_i,
  input  wire logic        nmi_i,
  input  wire logic        address_error_i,
  input  wire logic        standby_i,
  // Requester handshake
  input  wire logic        transfer_request_pin_n_i,
  output logic             request_accept_strobe_o,
  output logic             transfer_acknowledge_o,
  // Bus cycle view
  output logic             dma_cycle_o,
  output logic             dummy_cycle_o,
  output logic [AW-1:0]    src_addr_o,
  output logic [31:0]      dst_addr_o
);
  import dmars_pkg::*;

  typedef struct packed {
    dmars_state_type st;
    logic [7:0]       ctrl;
    logic             te;
    logic             ae;
    logic             nmif;
    logic [31:0]      dst;
    logic [CNT_W-1:0] cnt;
    logic [3:0]       wcnt;
    logic [1:0]       lat;
    logic [1:0]       plat;
    logic             pend;
    logic             samp_en;
    logic             cont;
    logic             req_prev;
    logic             accept;
    logic             wb_ack;
    logic [31:0]      wb_dat;
  } dmars_regs_type;

  dmars_regs_type s_r;
  dmars_regs_type s_nxt;

  logic [AW-1:0] src_addr;
  logic [AW-1:0] src_init;
  logic [AW-1:0] src_load;
  logic [1:0]    rl_phase;
  logic          src_wr;
  logic          step;
  logic          te_set;
  logic          rl_clear;
  logic          me;
  logic          ce;
  logic          edge_mode;
  logic          burst;
  logic          single;
  logic          edge_burst;
  logic          stop;
  logic          go;
  logic          detect;
  logic          sampled;
  logic          access;
  logic          wr;
  logic [3:0]    bus_states;
  logic [31:0]   ctrl_wr;
  logic [31:0]   cnt_wr;
  logic          last_unit;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    end
    merge = res;
  endfunction

  assign me         = s_r.ctrl[CTRL_ME];
  assign ce         = s_r.ctrl[CTRL_CE];
  assign edge_mode  = s_r.ctrl[CTRL_EDGE];
  assign burst      = s_r.ctrl[CTRL_BURST];
  assign single     = s_r.ctrl[CTRL_SINGLE];
  assign edge_burst = edge_mode & burst;
  // Halt requests stop the channel after the unit in progress
  assign stop = s_r.ae | s_r.nmif | nmi_i | address_error_i | ~me | ~ce;
  assign go   = me & ce & ~s_r.ae & ~s_r.nmif & (s_r.cnt != '0);
  assign detect = edge_mode ? (s_r.req_prev & ~transfer_request_pin_n_i)
                            : ~transfer_request_pin_n_i;
  // No new request on the last state of the last unit or while a halt is pending
  assign last_unit = (s_r.st == ST_XFER) & (s_r.wcnt == 4'h0)
                   & (s_r.cnt == CNT_W'(1));
  assign sampled = s_r.samp_en & go & detect & ~stop & ~last_unit;
  // Zero wait setting still means a one-state cycle
  assign bus_states = single ? wait_control_two_i
                             : wait_control_one_i;
  assign access = wb_cyc_i & wb_stb_i & ~s_r.wb_ack;
  // Writes land on the edge at which the master sees ack high
  assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & s_r.wb_ack;
  assign ctrl_wr = merge({24'h0, s_r.ctrl}, wb_dat_i, wb_sel_i);
  assign cnt_wr  = merge(32'(s_r.cnt), wb_dat_i, wb_sel_i);
  assign rl_clear = ~me | ~ce | te_set | nmi_i | address_error_i
                  | standby_i;

  always_comb begin
    s_nxt = s_r;
    step     = 1'b0;
    te_set   = 1'b0;
    src_wr   = 1'b0;
    src_load = src_init;
    s_nxt.accept   = 1'b0;
    s_nxt.req_prev = transfer_request_pin_n_i;
    s_nxt.wb_ack   = wb_cyc_i & wb_stb_i & ~s_r.wb_ack;
    if (s_r.lat != REQ_LATENCY)
      s_nxt.lat = s_r.lat + 2'h1;
    if (s_r.plat != REQ_LATENCY)
      s_nxt.plat = s_r.plat + 2'h1;

    // Register reads
    if (access) begin
      case (wb_adr_i)
        OFS_CTRL: s_nxt.wb_dat = {24'h0, s_r.ctrl};
        OFS_STAT: s_nxt.wb_dat = {26'h0, rl_phase,
                                  s_r.st != ST_IDLE,
                                  s_r.nmif, s_r.ae, s_r.te};
        OFS_SRC:  s_nxt.wb_dat = 32'(src_addr);
        OFS_DST:  s_nxt.wb_dat = s_r.dst;
        OFS_CNT:  s_nxt.wb_dat = 32'(s_r.cnt);
        default:  s_nxt.wb_dat = 32'h0;
      endcase
    end

    // Register writes
    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL: s_nxt.ctrl = ctrl_wr[7:0];
        OFS_SRC: begin
          src_wr   = 1'b1;
          src_load = AW'(merge(32'(src_init), wb_dat_i, wb_sel_i));
        end
        OFS_DST:  s_nxt.dst = merge(s_r.dst, wb_dat_i, wb_sel_i);
        OFS_CNT:  s_nxt.cnt = cnt_wr[CNT_W-1:0];
        default: ;
      endcase
    end

    // Request sequencing
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.cont    = 1'b0;
        s_nxt.pend    = 1'b0;
        s_nxt.samp_en = go;
      end
      ST_LAT: begin
        if (!go || stop) begin
          s_nxt.st      = ST_IDLE;
          s_nxt.samp_en = 1'b0;
        end else begin
          // Next sampling opens one cycle before the first bus cycle
          if (s_r.lat == LAT_PRE && !edge_burst && !s_r.pend)
            s_nxt.samp_en = 1'b1;
          if (s_r.lat == REQ_LATENCY) begin
            s_nxt.wcnt = bus_states - 4'h1;
            if (bus_states == 4'h0)
              s_nxt.wcnt = 4'h0;
            if (burst && single && !s_r.cont) begin
              s_nxt.st = ST_DUMMY;
            end else begin
              s_nxt.st      = ST_XFER;
              s_nxt.samp_en = s_r.samp_en | (~edge_burst & ~s_r.pend);
            end
          end
        end
      end
      ST_DUMMY: begin
        // Dummy cycle moves no data and leaves the count alone
        if (!me || !ce) begin
          s_nxt.st      = ST_IDLE;
          s_nxt.samp_en = 1'b0;
        end else if (s_r.wcnt != 4'h0) begin
          s_nxt.wcnt = s_r.wcnt - 4'h1;
        end else begin
          s_nxt.st      = ST_XFER;
          s_nxt.cont    = 1'b1;
          s_nxt.wcnt    = (bus_states == 4'h0) ? 4'h0
                                               : bus_states - 4'h1;
          s_nxt.samp_en = s_r.samp_en | (~edge_burst & ~s_r.pend);
        end
      end
      ST_XFER: begin
        if (s_r.wcnt != 4'h0) begin
          s_nxt.wcnt = s_r.wcnt - 4'h1;
        end else begin
          step      = 1'b1;
          s_nxt.cnt = s_r.cnt - CNT_W'(1);
          s_nxt.wcnt = (bus_states == 4'h0) ? 4'h0
                                            : bus_states - 4'h1;
          if (s_r.cnt == CNT_W'(1)) begin
            te_set        = 1'b1;
            s_nxt.st      = ST_IDLE;
            s_nxt.cont    = 1'b0;
            s_nxt.pend    = 1'b0;
            s_nxt.samp_en = 1'b0;
          end else if (stop) begin
            // Interrupted burst needs a fresh request and a new dummy
            s_nxt.st      = ST_IDLE;
            s_nxt.cont    = 1'b0;
            s_nxt.pend    = 1'b0;
            s_nxt.samp_en = 1'b0;
          end else if (edge_burst) begin
            s_nxt.st   = ST_XFER;
            s_nxt.cont = 1'b1;
          end else if (s_r.pend) begin
            s_nxt.pend = 1'b0;
            s_nxt.lat  = s_nxt.plat;
            if (burst && s_r.plat == REQ_LATENCY) begin
              s_nxt.st      = ST_XFER;
              s_nxt.cont    = 1'b1;
              s_nxt.samp_en = 1'b1;
            end else begin
              s_nxt.st   = ST_LAT;
              s_nxt.cont = burst;
            end
          end else begin
            s_nxt.st   = ST_IDLE;
            s_nxt.cont = 1'b0;
          end
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // One accept pulse for each request found by sampling
    if (sampled) begin
      s_nxt.accept  = 1'b1;
      s_nxt.samp_en = 1'b0;
      if (s_r.st == ST_IDLE) begin
        s_nxt.st  = ST_LAT;
        s_nxt.lat = 2'h1;
        // Resumed single edge burst starts again with a dummy
        s_nxt.cont = 1'b0;
      end else if (s_nxt.st == ST_IDLE) begin
        // Request met on the last state of a unit starts the next one
        s_nxt.st   = ST_LAT;
        s_nxt.lat  = 2'h1;
        s_nxt.cont = burst;
      end else begin
        s_nxt.pend = 1'b1;
        s_nxt.plat = 2'h1;
      end
    end

    // Flags: a hardware set wins over a clear in the same cycle
    if (wr && wb_adr_i == OFS_STAT && wb_sel_i[0]) begin
      s_nxt.te   = s_r.te   & ~wb_dat_i[STAT_TE];
      s_nxt.ae   = s_r.ae   & ~wb_dat_i[STAT_AE];
      s_nxt.nmif = s_r.nmif & ~wb_dat_i[STAT_NMIF];
    end
    if (te_set)
      s_nxt.te = 1'b1;
    if (address_error_i)
      s_nxt.ae = 1'b1;
    if (nmi_i)
      s_nxt.nmif = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r.st       <= ST_IDLE;
      s_r.ctrl     <= CTRL_RST;
      s_r.te       <= 1'b0;
      s_r.ae       <= 1'b0;
      s_r.nmif     <= 1'b0;
      s_r.dst      <= ADDR_RST;
      s_r.cnt      <= '0;
      s_r.wcnt     <= 4'h0;
      s_r.lat      <= 2'h0;
      s_r.plat     <= 2'h0;
      s_r.pend     <= 1'b0;
      s_r.samp_en  <= 1'b0;
      s_r.cont     <= 1'b0;
      s_r.req_prev <= 1'b1;
      s_r.accept   <= 1'b0;
      s_r.wb_ack   <= 1'b0;
      s_r.wb_dat   <= 32'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  dmars_reload #(
    .AW (AW)
  ) u_reload (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .load_i      (src_wr),
    .load_data_i (src_load),
    .step_i      (step),
    .size_i      (s_r.ctrl[CTRL_SIZE +: 2]),
    .reload_on_i (s_r.ctrl[CTRL_RELOAD]),
    .clear_i     (rl_clear),
    .addr_o      (src_addr),
    .init_o      (src_init),
    .phase_o     (rl_phase)
  );

  assign wb_ack_o = s_r.wb_ack;
  assign wb_dat_o = s_r.wb_dat;
  assign request_accept_strobe_o = s_r.accept;
  assign transfer_acknowledge_o  = (s_r.st == ST_XFER) & single;
  assign dma_cycle_o   = (s_r.st == ST_XFER) | (s_r.st == ST_DUMMY);
  assign dummy_cycle_o = (s_r.st == ST_DUMMY);
  assign src_addr_o    = src_addr;
  assign dst_addr_o    = s_r.dst;

endmodule // dmars_core

// ===== core/dmars_pkg.sv
/*
  Shared constants and types of the channel 2 request front end:
  register offsets, field positions, reset values and state codes.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package dmars_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam logic [4:0] OFS_SRC  = 5'h08;
  localparam logic [4:0] OFS_DST  = 5'h0c;
  localparam logic [4:0] OFS_CNT  = 5'h10;

  // Control register fields
  localparam int CTRL_ME     = 0;
  localparam int CTRL_CE     = 1;
  localparam int CTRL_EDGE   = 2;
  localparam int CTRL_BURST  = 3;
  localparam int CTRL_SINGLE = 4;
  localparam int CTRL_RELOAD = 5;
  localparam int CTRL_SIZE   = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Status register fields
  localparam int STAT_TE    = 0;
  localparam int STAT_AE    = 1;
  localparam int STAT_NMIF  = 2;
  localparam int STAT_BUSY  = 3;
  localparam int STAT_PHASE = 4;

  // Transfer unit codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // Count register width and reset values
  localparam int CNT_W = 24;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;

  // Least states from a detected request to the bus cycle it starts
  localparam logic [1:0] REQ_LATENCY = 2'h3;
  localparam logic [1:0] LAT_PRE     = 2'h2;
  // Source address returns to its start value every this many units
  localparam int RELOAD_EVERY = 4;
  localparam logic [1:0] RELOAD_LAST = 2'(RELOAD_EVERY - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LAT,
    ST_DUMMY,
    ST_XFER
  } dmars_state_type;

endpackage

// ===== core/dmars_reload.sv
/*
  Channel 2 source address with its four-unit reload counter.
  Assumes the caller pulses step_i once per real unit moved and
  holds clear_i during any event that must restart the counter.
*/
`timescale 1ns/100ps
module dmars_reload #(
  parameter int AW = 32
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Software load of the start address
  input  wire logic          load_i,
  input  wire logic [AW-1:0] load_data_i,
  // Transfer progress
  input  wire logic          step_i,
  input  wire logic [1:0]    size_i,
  input  wire logic          reload_on_i,
  input  wire logic          clear_i,
  // Current state
  output logic      [AW-1:0] addr_o,
  output logic      [AW-1:0] init_o,
  output logic      [1:0]    phase_o
);
  import dmars_pkg::*;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [AW-1:0] init;
    logic [1:0]    phase;
  } dmars_rl_type;

  dmars_rl_type s_r;
  dmars_rl_type s_nxt;

  function automatic logic [AW-1:0] unit_bytes(input logic [1:0] sz);
    case (sz)
      SIZE_HALF: unit_bytes = AW'(2);
      SIZE_WORD: unit_bytes = AW'(4);
      default:   unit_bytes = AW'(1);
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    if (load_i) begin
      s_nxt.init  = load_data_i;
      s_nxt.addr  = load_data_i;
      s_nxt.phase = 2'h0;
    end else if (step_i) begin
      if (reload_on_i && s_r.phase == RELOAD_LAST) begin
        s_nxt.addr  = s_r.init;
        s_nxt.phase = 2'h0;
      end else begin
        s_nxt.addr = s_r.addr + unit_bytes(size_i);
        if (reload_on_i)
          s_nxt.phase = s_r.phase + 2'h1;
      end
    end
    if (clear_i)
      s_nxt.phase = 2'h0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r.addr  <= ADDR_RST;
      s_r.init  <= ADDR_RST;
      s_r.phase <= 2'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign addr_o  = s_r.addr;
  assign init_o  = s_r.init;
  assign phase_o = s_r.phase;

endmodule // dmars_reload

// ===== verif/dmars_core_properties.sv
/*
  Port checker of the channel 2 request front end.
  Assumes one clock domain and is bound to every dmars_core.
*/
`timescale 1ns/100ps
module dmars_core_properties #(
  parameter int AW = 32
) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [4:0]    wb_adr_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  input wire logic [3:0]    wait_control_one_i,
  input wire logic [3:0]    wait_control_two_i,
  input wire logic          nmi_i,
  input wire logic          address_error_i,
  input wire logic          standby_i,
  input wire logic          transfer_request_pin_n_i,
  input wire logic          request_accept_strobe_o,
  input wire logic          transfer_acknowledge_o,
  input wire logic          dma_cycle_o,
  input wire logic          dummy_cycle_o,
  input wire logic [AW-1:0] src_addr_o,
  input wire logic [31:0]   dst_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  strobe_one_clock_a:
    assert property (request_accept_strobe_o |=> !request_accept_strobe_o)
      else $error("accept strobe wider than one clock");
  strobe_to_cycle_a:
    assert property ($rose(request_accept_strobe_o) |-> ##3 dma_cycle_o)
      else $error("bus cycle missing after accept strobe");
  no_early_cycle_a:
    assert property (request_accept_strobe_o && !dma_cycle_o
                     |=> !dma_cycle_o ##1 !dma_cycle_o)
      else $error("bus cycle started too early");
  dummy_no_ack_a:
    assert property (dummy_cycle_o |-> dma_cycle_o && !transfer_acknowledge_o)
      else $error("acknowledge during dummy cycle");
  ack_real_only_a:
    assert property (transfer_acknowledge_o |-> dma_cycle_o && !dummy_cycle_o)
      else $error("acknowledge outside a real transfer");
  dummy_then_xfer_a:
    assert property ($rose(dummy_cycle_o) |-> ##[1:16] transfer_acknowledge_o)
      else $error("no real transfer after dummy cycle");
  src_moves_a:
    assert property ($changed(src_addr_o) |-> $past(rst_i) || $past(wb_we_i)
                     || ($past(dma_cycle_o) && !$past(dummy_cycle_o)))
      else $error("source address moved outside a transfer");
  wb_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("register access not answered");
endmodule // dmars_core_properties

bind dmars_core dmars_core_properties #(.AW(AW)) props_u (.*);

// ===== verif/dmars_requester.sv
/*
  Requesting device: pulls the request low on go_i and releases it
  once the accept strobe was seen hold_i times. Idles high.
*/
`timescale 1ns/100ps
module dmars_requester (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [3:0] hold_i,
  input  wire logic       strobe_i,
  output logic            pin_n_o
);
  logic [3:0] left_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_n_o <= 1'b1;
      left_r  <= 4'h0;
    end else if (go_i) begin
      pin_n_o <= 1'b0;
      left_r  <= hold_i;
    end else if (strobe_i && left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
      if (left_r == 4'h1) begin
        pin_n_o <= 1'b1;
      end
    end
  end
endmodule // dmars_requester

// ===== verif/dma_request_sampling_reload_test.sv
/*
  Self-checking bench of the channel 2 request front end.
  Assumes classic Wishbone registers and the requester model.
*/
`timescale 1ns/100ps
module dma_request_sampling_reload_test;
  import dmars_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic        nmi_i = 1'b0;
  logic        go = 1'b0;
  logic        sby = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [3:0]  wc1 = 4'h1;
  logic [3:0]  wc2 = 4'h1;
  logic [3:0]  hold = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, strb, ack, dma, dum, pin_n;
  int          failures = 0, n_tests = 0, n_strb = 0, n_dum = 0, n_ack = 0;
  localparam logic [7:0] EN = 8'h3;

  always #25 clk_i = ~clk_i;

  dmars_core dut_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .nmi_i,
    .wait_control_one_i(wc1), .wait_control_two_i(wc2),
    .address_error_i(1'b0), .standby_i(sby),
    .transfer_request_pin_n_i(pin_n), .request_accept_strobe_o(strb),
    .transfer_acknowledge_o(ack), .dma_cycle_o(dma), .dummy_cycle_o(dum),
    .src_addr_o(), .dst_addr_o());
  dmars_requester req_u (.clk_i, .rst_i, .go_i(go), .hold_i(hold),
                         .strobe_i(strb), .pin_n_o(pin_n));

  // Running event counts; scenarios judge the differences
  always @(posedge clk_i) begin
    n_strb <= n_strb + int'(strb === 1'b1);
    n_dum  <= n_dum + int'(dum === 1'b1);
    n_ack  <= n_ack + int'(ack === 1'b1);
  end

  function automatic logic [7:0] f(int n);
    return 8'(1 << n);
  endfunction
  task automatic end_sim;
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(logic we, logic [4:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) begin
      failures++;
      end_sim();
    end
  endtask
  task automatic wait_cnt(logic [31:0] t);
    int k;
    k = 0;
    do begin
      wb(1'b0, OFS_CNT, 32'h0);
      k++;
    end while (rd > t && k < 100);
    if (k >= 100) begin
      failures++;
      end_sim();
    end
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while ((dma !== 1'b0 || pin_n !== 1'b1) && k < 200);
    if (k >= 200) begin
      failures++;
      end_sim();
    end
  endtask
  task automatic setup(logic [7:0] c, logic [31:0] s, logic [31:0] n);
    wb(1'b1, OFS_STAT, 32'h7);
    wb(1'b1, OFS_SRC, s);
    wb(1'b1, OFS_DST, 32'h0);
    wb(1'b1, OFS_CNT, n);
    wb(1'b1, OFS_CTRL, {24'h0, c});
  endtask
  task automatic kick(logic [3:0] h);
    @(posedge clk_i);
    hold <= h;
    go   <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask

  task automatic t_reset;
    wb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", {24'h0, CTRL_RST}, rd);
    wb(1'b0, OFS_SRC, 32'h0);
    chk("src", ADDR_RST, rd);
    wb(1'b1, 5'h14, 32'hffff_ffff);
    wb(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  // Cycle steal, single, level, reload on, request released after two strobes, phase cleared by standby
  task automatic t_steal;
    int s, a, d;
    s = n_strb;
    a = n_ack;
    d = n_dum;
    wc2 <= 4'h2;
    setup(EN | f(CTRL_SINGLE) | f(CTRL_RELOAD) | {SIZE_WORD, 6'h0},
          32'h100, 32'h4);
    kick(4'h2);
    wait_cnt(32'h2);
    wait_idle;
    chk("strobes", 32'h2, 32'(n_strb - s));
    chk("ack cycles", 32'h4, 32'(n_ack - a));
    chk("dummy cycles", 32'h0, 32'(n_dum - d));
    wb(1'b0, OFS_SRC, 32'h0);
    chk("src", 32'h108, rd);
    wb(1'b0, OFS_STAT, 32'h0);
    chk("phase", 32'h2, 32'(rd[5:4]));
    @(posedge clk_i);
    sby <= 1'b1;
    @(posedge clk_i);
    sby <= 1'b0;
    wb(1'b0, OFS_STAT, 32'h0);
    chk("standby phase", 32'h0, 32'(rd[5:4]));
    wb(1'b1, OFS_CTRL, {24'h0, f(CTRL_ME)});
    wb(1'b0, OFS_STAT, 32'h0);
    chk("phase", 32'h0, 32'(rd[5:4]));
    wb(1'b0, OFS_CNT, 32'h0);
    chk("count", 32'h2, rd);
  endtask
  // Burst, single, level: one dummy, then three units with ST_LAT states between them
  task automatic t_burst;
    int a, d;
    a = n_ack;
    d = n_dum;
    wc2 <= 4'h1;
    setup(EN | f(CTRL_BURST) | f(CTRL_SINGLE), 32'h200, 32'h3);
    kick(4'h3);
    wait_cnt(32'h0);
    wait_idle;
    chk("dummy cycles", 32'h1, 32'(n_dum - d));
    chk("ack cycles", 32'h3, 32'(n_ack - a));
    wb(1'b0, OFS_SRC, 32'h0);
    chk("src", 32'h203, rd);
  endtask
  // Edge burst, dual, reload on, every unit size
  task automatic t_reload;
    int s, a;
    for (int z = 0; z < 3; z++) begin
      s = n_strb;
      a = n_ack;
      setup(EN | f(CTRL_EDGE) | f(CTRL_BURST) | f(CTRL_RELOAD)
            | {2'(z), 6'h0}, 32'h300, 32'h8);
      kick(4'h1);
      wait_cnt(32'h0);
      wait_idle;
      chk("strobes", 32'h1, 32'(n_strb - s));
      chk("ack cycles", 32'h0, 32'(n_ack - a));
      wb(1'b0, OFS_SRC, 32'h0);
      chk("src", 32'h300, rd);
      wb(1'b0, OFS_STAT, 32'h0);
      chk("phase", 32'h0, 32'(rd[5:4]));
    end
  endtask
  // Edge burst, single, halted by NMI and resumed by a new edge
  task automatic t_nmi;
    int s, a, d;
    s = n_strb;
    a = n_ack;
    d = n_dum;
    wc2 <= 4'h3;
    setup(EN | f(CTRL_EDGE) | f(CTRL_BURST) | f(CTRL_SINGLE)
          | {SIZE_WORD, 6'h0}, 32'h400, 32'h6);
    kick(4'h1);
    wait_cnt(32'h4);
    @(posedge clk_i);
    nmi_i <= 1'b1;
    @(posedge clk_i);
    nmi_i <= 1'b0;
    wait_idle;
    wb(1'b0, OFS_STAT, 32'h0);
    chk("nmi flag", 32'h1, 32'(rd[STAT_NMIF]));
    wb(1'b1, OFS_STAT, 32'(f(STAT_NMIF)));
    kick(4'h1);
    wait_cnt(32'h0);
    wait_idle;
    chk("strobes", 32'h2, 32'(n_strb - s));
    chk("dummy cycles", 32'h6, 32'(n_dum - d));
    chk("ack cycles", 32'h12, 32'(n_ack - a));
    wb(1'b0, OFS_SRC, 32'h0);
    chk("src", 32'h418, rd);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_steal;
    t_burst;
    t_reload;
    t_nmi;
    end_sim;
  end
endmodule // dma_request_sampling_reload_test
